// ===== hdl/bbr_pkg.sv
// Behaviour
// - Each bit-band window is the bottom 1 MB of the SRAM and peripheral spaces, every bit reachable through an alias word.
// - A 32 MB SRAM alias window maps each word to one bit of the 1 MB SRAM bit-band window.
// - Plain accesses to 0x2000_0000..0x200F_FFFF pass through as ordinary SRAM accesses.
// - Data accesses to 0x2200_0000..0x23FF_FFFF are redirected to the SRAM bit-band window; fetches there are not redirected.
// - Plain accesses to 0x4000_0000..0x400F_FFFF pass through as ordinary peripheral accesses.
// - Data accesses to 0x4200_0000..0x43FF_FFFF are redirected to the peripheral bit-band window; fetches there are refused.
// - An alias write is a read of the underlying location, a change of one bit and a write back.
// - Alias address equals alias base plus byte offset times 32 plus bit number (0..7) times 4.
// - On an alias write, write-data bit 0 set sets the target bit and clear clears it.
// - Write-data bits 31..1 of an alias write are ignored.
// - An alias read returns 0x0000_0000 for a clear bit and 0x0000_0001 for a set bit.
// - The underlying access uses the same size as the alias access: word, halfword or byte.
// - Data is little-endian: byte n of the address sits on data lane n.
// - Peripheral accesses keep their order and the peripheral space never serves a fetch.
package bbr_pkg;
    localparam logic [31:0] SRAM_BB_BASE    = 32'h2000_0000;
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] PERI_BB_BASE    = 32'h4000_0000;
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
    localparam int          BB_BITS         = 20;
    localparam int          ALIAS_BITS      = 25;
    localparam logic [2:0]  PERI_REGION_TOP = 3'h2;
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_HALF       = 2'h1;
    localparam logic [1:0]  SIZE_WORD       = 2'h2;
    localparam logic [31:0] ALIAS_READ_ONE  = 32'h0000_0001;
    localparam logic [31:0] ALIAS_READ_ZERO = 32'h0000_0000;

    // Bit position on the 32-bit bus: lane from the byte address, then bit
    function automatic logic [4:0] bbr_lane_bit(input logic [1:0] lane,
                                                input logic [2:0] bitNum);
        return {lane, bitNum};
    endfunction

    function automatic logic [31:0] bbr_align(input logic [31:0] addr,
                                              input logic [1:0]  size);
        logic [31:0] res;
        res = addr;
        if (size == SIZE_WORD) begin
            res[1:0] = 2'h0;
        end else if (size == SIZE_HALF) begin
            res[0] = 1'b0;
        end
        return res;
    endfunction
endpackage

// ===== hdl/bbr_map_if.sv
`timescale 1ns/1ps
interface bbr_map_if;
    logic [31:0] addr;
    logic        fetch;
    logic [1:0]  size;
    logic        isAlias;
    logic        refuse;
    logic [31:0] tgtAddr;
    logic [4:0]  lanePos;

    modport decoder (input addr, fetch, size,
                     output isAlias, refuse, tgtAddr, lanePos);
    modport bridge  (output addr, fetch, size,
                     input isAlias, refuse, tgtAddr, lanePos);
endinterface

// ===== hdl/bbr_decode.sv
`timescale 1ns/1ps
module bbr_decode
    import bbr_pkg::*;
(
    bbr_map_if.decoder map
);
    logic        sramAlias;
    logic        periAlias;
    logic        periSpace;
    logic [31:0] bbByte;

    always_comb begin
        sramAlias = map.addr[31:ALIAS_BITS] ==
                    SRAM_ALIAS_BASE[31:ALIAS_BITS];
        periAlias = map.addr[31:ALIAS_BITS] ==
                    PERI_ALIAS_BASE[31:ALIAS_BITS];
        periSpace = map.addr[31:29] == PERI_REGION_TOP;
        // Byte in the bottom 1 MB picked by alias bits 24..5
        bbByte = {(sramAlias ? SRAM_BB_BASE[31:BB_BITS]
                             : PERI_BB_BASE[31:BB_BITS]),
                  map.addr[ALIAS_BITS-1:5]};
        map.refuse  = map.fetch && periSpace;
        // Fetches from the SRAM alias go through untouched
        map.isAlias = !map.fetch && (sramAlias || periAlias);
        map.tgtAddr = map.isAlias ? bbr_align(bbByte, map.size)
                                  : map.addr;
        map.lanePos = bbr_lane_bit(bbByte[1:0], map.addr[4:2]);
    end
endmodule

// ===== hdl/bbr_merge.sv
`timescale 1ns/1ps
module bbr_merge (
    input  wire logic [31:0] rdata,
    input  wire logic [4:0]  lanePos,
    input  wire logic        bitIn,
    output logic      [31:0] merged,
    output logic             bitOut
);
    always_comb begin
        bitOut          = rdata[lanePos];
        merged          = rdata;
        merged[lanePos] = bitIn;
    end
endmodule

// ===== hdl/bbr_bridge.sv
`timescale 1ns/1ps
module bbr_bridge
    import bbr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic [31:0] reqAddr,
    input  wire logic        reqWrite,
    input  wire logic        reqFetch,
    input  wire logic [1:0]  reqSize,
    input  wire logic [31:0] reqWdata,
    output logic             rspValid,
    output logic [31:0]      rspRdata,
    output logic             rspError,
    output logic             memValid,
    input  wire logic        memReady,
    output logic [31:0]      memAddr,
    output logic             memWrite,
    output logic [1:0]       memSize,
    output logic [31:0]      memWdata,
    input  wire logic [31:0] memRdata,
    input  wire logic        memError
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_DIRECT,
        S_ALIAS_RD,
        S_ALIAS_WR
    } bbr_state_t;

    bbr_state_t  state;
    logic        take;
    logic        done;
    logic        rdDone;
    logic        opWrite;
    logic        opBit;
    logic [4:0]  opLane;
    logic [31:0] mergedWord;
    logic        readBit;

    bbr_map_if mapIf ();

    assign mapIf.addr  = reqAddr;
    assign mapIf.fetch = reqFetch;
    assign mapIf.size  = reqSize;

    bbr_decode uDecode (
        .map (mapIf.decoder)
    );

    bbr_merge uMerge (
        .rdata   (memRdata),
        .lanePos (opLane),
        .bitIn   (opBit),
        .merged  (mergedWord),
        .bitOut  (readBit)
    );

    assign take   = reqValid && reqReady;
    assign rdDone = state == S_ALIAS_RD && memReady;
    // One access in flight at a time keeps peripheral order intact
    assign done   = (take && mapIf.refuse) ||
                    (memReady && (state == S_DIRECT ||
                                  state == S_ALIAS_WR)) ||
                    (rdDone && (!opWrite || memError));

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (take && !mapIf.refuse) begin
                        state <= mapIf.isAlias ? S_ALIAS_RD : S_DIRECT;
                    end
                end
                S_DIRECT: begin
                    if (memReady) begin
                        state <= S_IDLE;
                    end
                end
                S_ALIAS_RD: begin
                    if (memReady) begin
                        // Bus error on the read aborts the write back
                        state <= (opWrite && !memError) ? S_ALIAS_WR
                                                        : S_IDLE;
                    end
                end
                default: begin
                    if (memReady) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            opWrite <= 1'b0;
            opBit   <= 1'b0;
            opLane  <= 5'h00;
        end else if (take) begin
            opWrite <= reqWrite;
            opBit   <= reqWdata[0];
            opLane  <= mapIf.lanePos;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reqReady <= 1'b1;
        end else if (take && !mapIf.refuse) begin
            reqReady <= 1'b0;
        end else if (done) begin
            reqReady <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            memValid <= 1'b0;
            memAddr  <= 32'h0000_0000;
            memWrite <= 1'b0;
            memSize  <= SIZE_WORD;
            memWdata <= 32'h0000_0000;
        end else if (take && !mapIf.refuse) begin
            memValid <= 1'b1;
            memAddr  <= mapIf.tgtAddr;
            memWrite <= reqWrite && !mapIf.isAlias;
            memSize  <= reqSize;
            memWdata <= reqWdata;
        end else if (rdDone) begin
            memValid <= opWrite && !memError;
            memWrite <= 1'b1;
            memWdata <= mergedWord;
        end else if (memReady && memValid) begin
            memValid <= 1'b0;
            memWrite <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rspValid <= 1'b0;
            rspRdata <= 32'h0000_0000;
            rspError <= 1'b0;
        end else begin
            rspValid <= done;
            if (take && mapIf.refuse) begin
                rspRdata <= 32'h0000_0000;
                rspError <= 1'b1;
            end else if (state == S_DIRECT && memReady) begin
                rspRdata <= memRdata;
                rspError <= memError;
            end else if (rdDone) begin
                rspRdata <= readBit ? ALIAS_READ_ONE
                                    : ALIAS_READ_ZERO;
                rspError <= memError;
            end else if (state == S_ALIAS_WR && memReady) begin
                rspRdata <= 32'h0000_0000;
                rspError <= memError;
            end
        end
    end

    sequence s_alias_take;
        take && mapIf.isAlias && !mapIf.refuse;
    endsequence

    sequence s_rmw_read_done;
        rdDone && opWrite && !memError;
    endsequence

    property p_refuse_fetch;
        @(posedge mclk) disable iff (rst)
        take && reqFetch && reqAddr[31:29] == PERI_REGION_TOP
        |=> rspValid && rspError && !memValid;
    endproperty
    a_refuse_fetch: assert property (p_refuse_fetch)
        else $error("peripheral fetch not refused");

    property p_alias_target;
        @(posedge mclk) disable iff (rst)
        s_alias_take |=> memValid && !memWrite &&
            memAddr[BB_BITS-1:2] == $past(reqAddr[ALIAS_BITS-1:7]) &&
            (memAddr[31:BB_BITS] == SRAM_BB_BASE[31:BB_BITS] ||
             memAddr[31:BB_BITS] == PERI_BB_BASE[31:BB_BITS]);
    endproperty
    a_alias_target: assert property (p_alias_target)
        else $error("alias address mapped wrongly");

    property p_sram_fetch_plain;
        @(posedge mclk) disable iff (rst)
        take && reqFetch &&
            reqAddr[31:ALIAS_BITS] == SRAM_ALIAS_BASE[31:ALIAS_BITS]
        |=> memValid && memAddr == $past(reqAddr);
    endproperty
    a_sram_fetch_plain: assert property (p_sram_fetch_plain)
        else $error("SRAM alias fetch was remapped");

    property p_direct_pass;
        @(posedge mclk) disable iff (rst)
        take && !mapIf.isAlias && !mapIf.refuse
        |=> memValid && memAddr == $past(reqAddr) &&
            memWrite == $past(reqWrite) && memWdata == $past(reqWdata);
    endproperty
    a_direct_pass: assert property (p_direct_pass)
        else $error("direct access altered");

    property p_size_kept;
        @(posedge mclk) disable iff (rst)
        take && !mapIf.refuse |=> memSize == $past(reqSize);
    endproperty
    a_size_kept: assert property (p_size_kept)
        else $error("access size changed");

    property p_rmw_writeback;
        @(posedge mclk) disable iff (rst)
        s_rmw_read_done |=> memValid && memWrite &&
            memWdata[opLane] == opBit;
    endproperty
    a_rmw_writeback: assert property (p_rmw_writeback)
        else $error("alias write back missing or wrong bit");

    property p_other_bits_kept;
        @(posedge mclk) disable iff (rst)
        s_rmw_read_done |=> (memWdata ^ $past(memRdata)) ==
            (32'h0000_0001 << opLane) * 32'($past(memRdata[opLane]) ^ opBit);
    endproperty
    a_other_bits_kept: assert property (p_other_bits_kept)
        else $error("alias write touched other bits");

    property p_alias_read_value;
        @(posedge mclk) disable iff (rst)
        rdDone && !opWrite |=> rspValid &&
            rspRdata == {31'h0000_0000, $past(memRdata[opLane])};
    endproperty
    a_alias_read_value: assert property (p_alias_read_value)
        else $error("alias read value wrong");

    property p_hold_order;
        @(posedge mclk) disable iff (rst)
        memValid && !memReady |=> memValid && $stable(memAddr) &&
            $stable(memWrite) && !reqReady;
    endproperty
    a_hold_order: assert property (p_hold_order)
        else $error("pending access changed before completion");

    sequence s_wb_done;
        state == S_ALIAS_WR && memReady;
    endsequence

    property p_reset_idle;
        @(posedge mclk)
        rst |=> reqReady && !rspValid && !rspError && !memValid;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("bridge not idle after reset");

    property p_ready_with_rsp;
        @(posedge mclk) disable iff (rst)
        rspValid |-> reqReady && !memValid;
    endproperty
    a_ready_with_rsp: assert property (p_ready_with_rsp)
        else $error("response given while access still open");

    property p_direct_answer;
        @(posedge mclk) disable iff (rst)
        state == S_DIRECT && memReady |=> rspValid &&
            rspRdata == $past(memRdata) && rspError == $past(memError);
    endproperty
    a_direct_answer: assert property (p_direct_answer)
        else $error("direct read data not passed back");

    property p_alias_lane;
        @(posedge mclk) disable iff (rst)
        s_alias_take |=>
            opLane == {$past(reqAddr[6:5]), $past(reqAddr[4:2])};
    endproperty
    a_alias_lane: assert property (p_alias_lane)
        else $error("alias bit lane picked wrongly");

    property p_alias_base;
        @(posedge mclk) disable iff (rst)
        s_alias_take |=> memAddr[31:BB_BITS] == ($past(reqAddr[30]) ?
            PERI_BB_BASE[31:BB_BITS] : SRAM_BB_BASE[31:BB_BITS]);
    endproperty
    a_alias_base: assert property (p_alias_base)
        else $error("alias mapped into the wrong space");

    property p_alias_aligned;
        @(posedge mclk) disable iff (rst)
        s_alias_take |=> (memSize != SIZE_WORD || memAddr[1:0] == 2'h0) &&
            (memSize != SIZE_HALF || !memAddr[0]);
    endproperty
    a_alias_aligned: assert property (p_alias_aligned)
        else $error("alias target not aligned to access size");

    property p_alias_write_answer;
        @(posedge mclk) disable iff (rst)
        s_wb_done |=> rspValid && rspRdata == 32'h0000_0000 &&
            rspError == $past(memError);
    endproperty
    a_alias_write_answer: assert property (p_alias_write_answer)
        else $error("alias write answer wrong");

    property p_alias_read_ends;
        @(posedge mclk) disable iff (rst)
        rdDone && !opWrite |=> !memValid && reqReady && state == S_IDLE;
    endproperty
    a_alias_read_ends: assert property (p_alias_read_ends)
        else $error("alias read went on to a write");
endmodule

// ===== verification/bbr_mem_model.sv
`timescale 1ns/1ps
module bbr_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        memValid,
    input  wire logic [31:0] memAddr,
    input  wire logic        memWrite,
    input  wire logic [1:0]  memSize,
    input  wire logic [31:0] memWdata,
    output logic             memReady,
    output logic [31:0]      memRdata,
    output logic             memError
);
    logic [31:0] store [logic [31:0]];
    logic [31:0] lastAddr;
    logic [1:0]  lastSize;
    logic [31:0] word;
    logic [31:0] mask;
    logic [31:0] wa;
    int          accCnt;
    int          waitLeft;

    // Every access to this word answers with a bus error
    localparam logic [31:0] ERR_WORD = 32'h2008_0000;

    initial begin
        memReady = 1'b0;
        memError = 1'b0;
        memRdata = 32'h0;
        lastAddr = 32'h0;
        lastSize = 2'h0;
        accCnt   = 0;
        waitLeft = 0;
    end

    always @(posedge mclk) begin
        wa   = {memAddr[31:2], 2'h0};
        word = store.exists(wa) ? store[wa] : 32'h0;
        mask = (memSize == 2'h2) ? 32'hFFFF_FFFF :
               (memSize == 2'h1) ? (32'hFFFF << {memAddr[1], 4'h0}) :
               (32'hFF << {memAddr[1:0], 3'h0});
        memReady <= 1'b0;
        memError <= 1'b0;
        // Stale read data scrambled so nothing leans on a held value
        memRdata <= ~memRdata;
        if (!rst && memValid && !memReady) begin
            if (waitLeft == 0) begin
                memReady <= 1'b1;
                memRdata <= word;
                memError <= wa == ERR_WORD;
                lastAddr <= memAddr;
                lastSize <= memSize;
                accCnt   <= accCnt + 1;
                waitLeft = $urandom_range(3);
                if (memWrite) begin
                    store[wa] = (word & ~mask) | (memWdata & mask);
                end
            end else begin
                waitLeft--;
            end
        end
    end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bbr_pkg::*;
    logic        mclk, rst, reqValid, reqReady, reqWrite, reqFetch;
    logic        rspValid, rspError, memValid, memReady, memWrite, memError;
    logic [1:0]  reqSize, memSize, sz;
    logic [31:0] reqAddr, reqWdata, rspRdata, memAddr, memWdata, memRdata;
    logic [31:0] rd, b, a, w, m, old, wd, ex;
    logic [31:0] lastA;
    logic [1:0]  lastS;
    int          accN;
    logic [2:0]  n;
    logic        er;
    int          mismatches, check_count, cnt, op;
    logic [31:0] shadow [logic [31:0]];
    logic [31:0] cA [4] = '{32'h23FF_FFE0, 32'h23FF_FFFC, 32'h2200_0000,
                            32'h2200_001C};
    logic [31:0] cB [4] = '{32'h200F_FFFF, 32'h200F_FFFF, 32'h2000_0000,
                            32'h2000_0000};
    logic [2:0]  cN [4] = '{3'h0, 3'h7, 3'h0, 3'h7};

    bbr_bridge i_bbr_bridge (.mclk(mclk), .rst(rst), .reqValid(reqValid),
        .reqReady(reqReady), .reqAddr(reqAddr), .reqWrite(reqWrite),
        .reqFetch(reqFetch), .reqSize(reqSize), .reqWdata(reqWdata),
        .rspValid(rspValid), .rspRdata(rspRdata), .rspError(rspError),
        .memValid(memValid), .memReady(memReady), .memAddr(memAddr),
        .memWrite(memWrite), .memSize(memSize), .memWdata(memWdata),
        .memRdata(memRdata), .memError(memError));
    bbr_mem_model i_bbr_mem_model (.mclk(mclk), .rst(rst),
        .memValid(memValid), .memAddr(memAddr), .memWrite(memWrite),
        .memSize(memSize), .memWdata(memWdata), .memReady(memReady),
        .memRdata(memRdata), .memError(memError));

    assign lastA = i_bbr_mem_model.lastAddr;
    assign lastS = i_bbr_mem_model.lastSize;
    assign accN  = i_bbr_mem_model.accCnt;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] lmask(input logic [31:0] x,
                                          input logic [1:0]  s);
        if (s == SIZE_WORD) return 32'hFFFF_FFFF;
        if (s == SIZE_HALF) return 32'hFFFF << {x[1], 4'h0};
        return 32'hFF << {x[1:0], 3'h0};
    endfunction

    // Alias word = alias base + byte offset * 32 + bit * 4
    function automatic logic [31:0] to_alias(input logic [31:0] x,
                                             input logic [2:0]  k);
        return (x[30] ? PERI_ALIAS_BASE : SRAM_ALIAS_BASE) +
               {7'h0, x[19:0], 5'h0} + {27'h0, k, 2'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called at a falling edge; returns at the falling edge of the response
    task automatic xfer(input logic [31:0] ad, input logic wr, fe,
                        input logic [1:0] s, input logic [31:0] d);
        int t;
        t = 0;
        reqValid = 1'b1;
        reqAddr = ad;
        reqWrite = wr;
        reqFetch = fe;
        reqSize = s;
        reqWdata = d;
        while (reqReady !== 1'b1 && t < 50) begin
            @(negedge mclk);
            t++;
        end
        @(negedge mclk);
        reqValid = 1'b0;
        while (rspValid !== 1'b1 && t < 100) begin
            @(negedge mclk);
            t++;
        end
        chk("response seen", 32'h1, {31'h0, rspValid});
        rd = rspRdata;
        er = rspError;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        test_done;
    end

    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        reqAddr = 32'h0;
        reqWrite = 1'b0;
        reqFetch = 1'b0;
        reqSize = SIZE_WORD;
        reqWdata = 32'h0;
        mismatches = 0;
        check_count = 0;
        void'($urandom(32'h242BFCD2));
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        for (int i = 0; i < 90; i++) begin
            b = ($urandom_range(1) ? PERI_BB_BASE : SRAM_BB_BASE) |
                ($urandom_range(1) ? 32'h000F_FFF0 : 32'h0) |
                32'($urandom_range(15));
            sz = 2'($urandom_range(2));
            n = 3'($urandom);
            wd = $urandom;
            op = $urandom_range(3);
            a = b & ~{30'h0, sz[1], |sz};
            m = lmask(a, sz);
            w = {b[31:2], 2'h0};
            old = shadow.exists(w) ? shadow[w] : 32'h0;
            cnt = i_bbr_mem_model.accCnt;
            if (op == 0) begin
                xfer(a, 1'b1, 1'b0, sz, wd);
                shadow[w] = (old & ~m) | (wd & m);
            end else if (op == 1) begin
                xfer(a, 1'b0, 1'b0, sz, 32'h0);
                chk("direct read", old & m, rd & m);
            end else begin
                xfer(to_alias(b, n), op == 2, 1'b0, sz, wd);
                chk("alias size", 32'(sz), 32'(lastS));
                chk("alias target", a, lastA);
                if (op == 2) begin
                    old[{b[1:0], n}] = wd[0];
                    shadow[w] = old;
                    chk("rmw accesses", 32'(cnt + 2), 32'(accN));
                end else begin
                    ex = {31'h0, old[{b[1:0], n}]};
                    chk("alias read", ex, rd);
                end
            end
        end
        $display("test random mix done");
        foreach (shadow[k]) begin
            xfer(k, 1'b0, 1'b0, SIZE_WORD, 32'h0);
            chk("word after bit writes", shadow[k], rd);
        end
        $display("test sweep done");
        for (int k = 0; k < 4; k++) begin
            w = {cB[k][31:2], 2'h0};
            old = shadow.exists(w) ? shadow[w] : 32'h0;
            xfer(cA[k], 1'b0, 1'b0, SIZE_BYTE, 32'h0);
            chk("corner target", cB[k], lastA);
            chk("corner bit", {31'h0, old[{cB[k][1:0], cN[k]}]}, rd);
        end
        $display("test corner aliases done");
        cnt = i_bbr_mem_model.accCnt;
        xfer(32'h4200_0010, 1'b0, 1'b1, SIZE_WORD, 32'h0);
        chk("alias fetch error", 32'h1, {31'h0, er});
        chk("alias fetch data", 32'h0, rd);
        xfer(32'h4000_0004, 1'b0, 1'b1, SIZE_WORD, 32'h0);
        chk("peri fetch error", 32'h1, {31'h0, er});
        chk("no access", 32'(cnt), 32'(accN));
        xfer(32'h2200_0040, 1'b0, 1'b1, SIZE_WORD, 32'h0);
        chk("sram fetch error", 32'h0, {31'h0, er});
        chk("sram fetch addr", 32'h2200_0040, lastA);
        $display("test fetches done");
        cnt = accN;
        xfer(to_alias(32'h2008_0000, 3'h5), 1'b1, 1'b0, SIZE_WORD, 32'h1);
        chk("rmw bus error", 32'h1, {31'h0, er});
        chk("rmw write back", 32'(cnt + 1), 32'(accN));
        xfer(32'h2008_0000, 1'b0, 1'b0, SIZE_WORD, 32'h0);
        chk("direct bus error", 32'h1, {31'h0, er});
        $display("test bus errors done");
        test_done;
    end
endmodule
